// ### remote_cmd_pkg.sv
// Purpose: constants and types for the remote command parser, plus the
//          nonvolatile mask store that the parser instantiates
// Assumes: one 50 MHz clock; byte stream from link logic on the same clock
// Notes:   command words are held as right-justified upper-case ASCII
//
// What this block does
// - Channel A error codes 1 to 5 set event bits 0 to 4.
// - Channel A finished positioning sets event bit 5.
// - Setting above instrument maximum resets that channel and sets bit 6.
// - Channel B error codes 1 to 5 set event bits 0 to 4.
// - Channel B finished positioning sets event bit 5.
// - Reading an event register clears every bit that a new event does not set in the same cycle.
// - Enable masks can be saved to nonvolatile store, reloaded after a warm reset; power-on clears the store.
// - Upper and lower case letters match alike.
// - Qualifier joins the root word directly, no space or symbol between.
// - Operand may follow directly or after a space; optional operands may be omitted.
// - Semicolon or line feed ends a command; commands may be chained.
// - State query with question mark replies 1 for on, 0 for off.
// - Value query with question mark replies the present value.
// - Opto check on/off applies to the active channel.
// - Value set enters value mode unless its setting is above the instrument maximum; attenuator 0-99.99, phase 0-999.8.
// - Each event register has an 8-bit enable mask, 0-255, readable back.

`default_nettype none

package remote_cmd_pkg;
	// ascii codes
	localparam logic [7:0] ASC_SEMI = 8'h3B;
	localparam logic [7:0] ASC_LF = 8'h0A;
	localparam logic [7:0] ASC_SPACE = 8'h20;
	localparam logic [7:0] ASC_QUERY = 8'h3F;
	localparam logic [7:0] ASC_DOT = 8'h2E;
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] ASC_NINE = 8'h39;
	localparam logic [7:0] ASC_UP_A = 8'h41;
	localparam logic [7:0] ASC_UP_Z = 8'h5A;
	localparam logic [7:0] ASC_LO_A = 8'h61;
	localparam logic [7:0] ASC_LO_Z = 8'h7A;
	localparam logic [7:0] CASE_GAP = 8'h20;

	// command words, right-justified
	localparam logic [63:0] WORD_OPTO = 64'h000000004F50544F;
	localparam logic [63:0] WORD_OPTO_ON = 64'h00004F50544F4F4E;
	localparam logic [63:0] WORD_OPTO_OFF = 64'h004F50544F4F4646;
	localparam logic [63:0] WORD_VALUE_SET = 64'h0000000056534554;
	localparam logic [63:0] WORD_SEL_FIRST = 64'h0000004348414E41;
	localparam logic [63:0] WORD_SEL_SECOND = 64'h0000004348414E42;
	localparam logic [63:0] WORD_A_STATUS = 64'h0000000045535243;
	localparam logic [63:0] WORD_B_STATUS = 64'h0000000045535244;
	localparam logic [63:0] WORD_A_ENABLE = 64'h0000000045534345;
	localparam logic [63:0] WORD_B_ENABLE = 64'h0000000045534445;
	localparam logic [63:0] WORD_SAVE_MASKS = 64'h0000000000505343;

	// settings as bcd ddd.dd
	localparam logic [19:0] MAX_ATTEN_BCD = 20'h09999;
	localparam logic [19:0] MAX_PHASE_BCD = 20'h99980;
	localparam logic [19:0] SETTING_RESET = 20'h00000;

	// event register layout
	localparam int EVT_POSITIONED_BIT = 5;
	localparam int EVT_OUT_OF_RANGE_BIT = 6;
	localparam logic [2:0] ERR_CODE_FIRST = 3'h1;
	localparam logic [2:0] ERR_CODE_LAST = 3'h5;
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [8:0] MASK_LIMIT = 9'h0FF;
	localparam logic [8:0] BIN_SATURATE = 9'h100;

	// reply lengths in characters, line feed included
	localparam logic [2:0] REPLY_LEN_FLAG = 3'h2;
	localparam logic [2:0] REPLY_LEN_BYTE = 3'h4;
	localparam logic [2:0] REPLY_LEN_SETTING = 3'h7;
	localparam int FRAC_DIGITS = 2;

	// parser states
	typedef enum logic [5:0] {
		S_LOAD = 6'h01,
		S_WORD = 6'h02,
		S_OPER = 6'h04,
		S_SKIP = 6'h08,
		S_EXEC = 6'h10,
		S_REPLY = 6'h20
	} parse_state_t;

	// per-channel events from the instrument controller
	typedef struct packed {
		logic [2:0] err_code; // 0 none, 1..5 error code
		logic positioned; // one-cycle pulse
	} chan_event_t;

	// per-channel control outputs
	typedef struct packed {
		logic opto_enable;
		logic [19:0] setting;
	} chan_ctrl_t;
endpackage : remote_cmd_pkg

// nonvolatile store for the two enable masks; cleared only by power-on
module mask_store
(
	input wire logic clk, // system clock
	input wire logic npor, // power-on reset, sync, active low
	input wire logic wr_en, // save both masks
	input wire logic [15:0] wr_data, // {channel b mask, channel a mask}
	output logic [15:0] rd_data // registered stored masks
);
	logic [7:0] mem [2];

	// storage survives the warm reset
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (!npor)
				mem[i] <= 8'h00;
			else if (wr_en)
				mem[i] <= wr_data[i*8 +: 8];
		end
	end

	// registered read port
	always_ff @(posedge clk)
	begin
		rd_data <= {mem[1], mem[0]};
	end
endmodule // mask_store

`default_nettype wire

// ### remote_command_status_parser.sv
// Purpose: parse remote text commands and keep per-channel event status
// Assumes: rx and tx byte streams come from link logic on clk
// Notes:   replies are fixed width decimal text ending in a line feed

`default_nettype none

module remote_command_status_parser
(
	input wire logic clk, // 50 MHz clock
	input wire logic nrst, // sync reset, active low
	input wire logic npor, // power-on reset of the mask store
	input wire logic rx_valid, // command byte offered
	input wire logic [7:0] rx_data, // command byte
	output logic rx_ready, // byte taken when valid
	output logic tx_valid, // reply byte offered
	output logic [7:0] tx_data, // reply byte
	input wire logic tx_ready, // host takes reply byte
	input wire remote_cmd_pkg::chan_event_t [1:0] chan_ev, // instrument events
	input wire logic [1:0] inst_phase, // 1 phase changer, 0 attenuator
	output remote_cmd_pkg::chan_ctrl_t [1:0] chan_ctrl, // opto and setting
	output logic active_chan, // 0 channel a, 1 channel b
	output logic value_mode, // value mode selected
	output logic move_strobe, // pulse: move active instrument
	output logic [1:0] chan_reset, // pulse: reset channel
	output logic [1:0] ev_summary // enabled events pending
);
	import remote_cmd_pkg::*;

	parse_state_t state;
	parse_state_t next_state;
	logic [63:0] word;
	logic query;
	logic have_op;
	logic frac_mode;
	logic [1:0] frac_cnt;
	logic [11:0] int_bcd;
	logic [7:0] frac_bcd;
	logic too_big;
	logic [8:0] bin;
	logic [7:0] esr [2];
	logic [7:0] mask [2];
	logic [55:0] rbuf;
	logic [2:0] rlen;
	logic [15:0] store_rd;

	// byte classification
	wire take = rx_valid && rx_ready;
	wire is_lower = (rx_data >= ASC_LO_A) && (rx_data <= ASC_LO_Z);
	wire [7:0] ch = is_lower ? rx_data - CASE_GAP : rx_data;
	wire is_letter = (ch >= ASC_UP_A) && (ch <= ASC_UP_Z);
	wire is_digit = (ch >= ASC_ZERO) && (ch <= ASC_NINE);
	wire is_dot = ch == ASC_DOT;
	wire is_space = ch == ASC_SPACE;
	wire is_query = ch == ASC_QUERY;
	wire is_term = (ch == ASC_SEMI) || (ch == ASC_LF);
	wire [3:0] digit = ch[3:0];
	wire word_full = word[63:56] != 8'h00;
	wire in_cmd = (state == S_WORD) || (state == S_OPER);
	wire exec = state == S_EXEC;
	wire clr = exec || (state == S_LOAD) || ((state == S_SKIP) && take && is_term);

	// command decode
	wire m_opto_q = word == WORD_OPTO;
	wire m_opto_on = word == WORD_OPTO_ON;
	wire m_opto_off = word == WORD_OPTO_OFF;
	wire m_value_setting_command = word == WORD_VALUE_SET;
	wire m_sel_a = word == WORD_SEL_FIRST;
	wire m_sel_b = word == WORD_SEL_SECOND;
	wire m_esr_a = word == WORD_A_STATUS;
	wire m_esr_b = word == WORD_B_STATUS;
	wire m_en_a = word == WORD_A_ENABLE;
	wire m_en_b = word == WORD_B_ENABLE;
	wire m_save = word == WORD_SAVE_MASKS;

	// value set checks against the active instrument's maximum
	wire [19:0] op_bcd = {int_bcd, frac_bcd};
	wire [19:0] chan_max = inst_phase[active_chan] ? MAX_PHASE_BCD : MAX_ATTEN_BCD;
	wire value_setting_command_do = exec && m_value_setting_command && !query && have_op;
	wire value_setting_command_bad = value_setting_command_do && (too_big || (op_bcd > chan_max));
	wire value_setting_command_ok = value_setting_command_do && !value_setting_command_bad;
	wire value_setting_command_mode = exec && m_value_setting_command && !query && !(have_op && value_setting_command_bad);
	wire mask_ok = have_op && !query && (bin <= MASK_LIMIT);
	wire wr_mask_a = exec && m_en_a && mask_ok;
	wire wr_mask_b = exec && m_en_b && mask_ok;
	wire [1:0] rd_clr = {exec && m_esr_b && query, exec && m_esr_a && query};
	wire save_go = exec && m_save;
	wire opto_set = exec && !query && (m_opto_on || m_opto_off);
	wire [1:0] oor_set = {value_setting_command_bad && active_chan, value_setting_command_bad && !active_chan};
	wire reply_go = exec && query &&
		(m_value_setting_command || m_opto_q || m_esr_a || m_esr_b || m_en_a || m_en_b);

	// binary to bcd for 8-bit register replies
	function automatic logic [11:0] byte_to_bcd(input logic [7:0] v);
		logic [19:0] sh;
		sh = {12'h000, v};
		for (int i = 0; i < 8; i++)
		begin
			if (sh[11:8] > 4'h4)
				sh[11:8] = sh[11:8] + 4'h3;
			if (sh[15:12] > 4'h4)
				sh[15:12] = sh[15:12] + 4'h3;
			if (sh[19:16] > 4'h4)
				sh[19:16] = sh[19:16] + 4'h3;
			sh = {sh[18:0], 1'b0};
		end
		return sh[19:8];
	endfunction

	// reply text selection
	wire [7:0] byte_val = m_esr_a ? esr[0] : m_esr_b ? esr[1] :
		m_en_a ? mask[0] : mask[1];
	wire [11:0] byte_bcd = byte_to_bcd(byte_val);
	wire [19:0] act_set = chan_ctrl[active_chan].setting;
	wire [55:0] reply_flag = {ASC_ZERO | {7'h00, chan_ctrl[active_chan].opto_enable},
		ASC_LF, 40'h0000000000};
	wire [55:0] reply_byte = {ASC_ZERO | {4'h0, byte_bcd[11:8]},
		ASC_ZERO | {4'h0, byte_bcd[7:4]}, ASC_ZERO | {4'h0, byte_bcd[3:0]},
		ASC_LF, 24'h000000};
	wire [55:0] reply_set = {ASC_ZERO | {4'h0, act_set[19:16]},
		ASC_ZERO | {4'h0, act_set[15:12]}, ASC_ZERO | {4'h0, act_set[11:8]},
		ASC_DOT, ASC_ZERO | {4'h0, act_set[7:4]}, ASC_ZERO | {4'h0, act_set[3:0]},
		ASC_LF};
	wire [55:0] reply_sel = m_opto_q ? reply_flag : m_value_setting_command ? reply_set : reply_byte;
	wire [2:0] len_sel = m_opto_q ? REPLY_LEN_FLAG :
		m_value_setting_command ? REPLY_LEN_SETTING : REPLY_LEN_BYTE;

	// saturating decimal accumulator for mask operands
	wire [12:0] bin_x10 = {4'h0, bin} * 13'h00A + {9'h000, digit};
	wire [8:0] bin_next = (bin_x10 > {4'h0, MASK_LIMIT}) ? BIN_SATURATE : bin_x10[8:0];

	// handshake outputs
	assign rx_ready = in_cmd || (state == S_SKIP);
	assign tx_valid = state == S_REPLY;

	// parser sequence
	always_comb
	begin
		next_state = state;
		case (state)
			S_LOAD:
				next_state = S_WORD;
			S_WORD:
				if (take)
				begin
					if (is_term)
						next_state = S_EXEC;
					else if (is_letter)
						next_state = word_full ? S_SKIP : S_WORD;
					else if (is_digit || is_dot || is_space || is_query)
						next_state = S_OPER;
					else
						next_state = S_SKIP;
				end
			S_OPER:
				if (take)
				begin
					if (is_term)
						next_state = S_EXEC;
					else if (!(is_digit || is_dot || is_space || is_query))
						next_state = S_SKIP;
				end
			S_SKIP:
				if (take && is_term)
					next_state = S_WORD;
			S_EXEC:
				next_state = reply_go ? S_REPLY : S_WORD;
			S_REPLY:
				if (tx_ready && (rlen == 3'h1))
					next_state = S_WORD;
			default:
				next_state = S_WORD;
		endcase
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!nrst)
			state <= S_LOAD;
		else
			state <= next_state;
	end

	// command word and query flag
	always_ff @(posedge clk)
	begin
		if (!nrst || clr)
		begin
			word <= 64'h0000000000000000;
			query <= 1'b0;
		end
		else if (take && (state == S_WORD) && is_letter && !word_full)
			word <= {word[55:0], ch};
		else if (take && in_cmd && is_query)
			query <= 1'b1;
	end

	// decimal operand, integer and fraction digits kept as bcd
	always_ff @(posedge clk)
	begin
		if (!nrst || clr)
		begin
			have_op <= 1'b0;
			frac_mode <= 1'b0;
			frac_cnt <= 2'h0;
			int_bcd <= 12'h000;
			frac_bcd <= 8'h00;
			too_big <= 1'b0;
			bin <= 9'h000;
		end
		else if (take && in_cmd && is_dot)
			frac_mode <= 1'b1;
		else if (take && in_cmd && is_digit)
		begin
			have_op <= 1'b1;
			bin <= bin_next;
			if (!frac_mode)
			begin
				int_bcd <= {int_bcd[7:0], digit};
				too_big <= too_big || (int_bcd[11:8] != 4'h0);
			end
			else if (frac_cnt < FRAC_DIGITS[1:0])
			begin
				frac_cnt <= frac_cnt + 2'h1;
				if (frac_cnt == 2'h0)
					frac_bcd[7:4] <= digit;
				else
					frac_bcd[3:0] <= digit;
			end
		end
	end

	// channel selection and value mode
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			active_chan <= 1'b0;
			value_mode <= 1'b0;
		end
		else
		begin
			if (exec && m_sel_a)
				active_chan <= 1'b0;
			else if (exec && m_sel_b)
				active_chan <= 1'b1;
			if (value_setting_command_mode)
				value_mode <= 1'b1;
		end
	end

	// one-cycle strobes toward the instrument controller
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			move_strobe <= 1'b0;
			chan_reset <= 2'b00;
		end
		else
		begin
			move_strobe <= value_setting_command_ok;
			chan_reset <= oor_set;
		end
	end

	// per-channel control, event register and enable mask
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			wire [2:0] code = chan_ev[gi].err_code;
			wire code_ok = (code >= ERR_CODE_FIRST) && (code <= ERR_CODE_LAST);
			wire [7:0] err_bits = code_ok ? 8'(8'h01 << (code - ERR_CODE_FIRST)) :
				8'h00;
			wire [7:0] pos_bit = {7'h00, chan_ev[gi].positioned} << EVT_POSITIONED_BIT;
			wire [7:0] oor_bit = {7'h00, oor_set[gi]} << EVT_OUT_OF_RANGE_BIT;
			wire sel = active_chan == 1'(gi);
			wire wr_mask = (gi == 0) ? wr_mask_a : wr_mask_b;

			// sticky bits, a new event wins over the read clear
			always_ff @(posedge clk)
			begin
				if (!nrst)
					esr[gi] <= EVENT_RESET;
				else
					esr[gi] <= (rd_clr[gi] ? 8'h00 : esr[gi]) | err_bits | pos_bit |
						oor_bit;
			end

			// enable mask, reloaded from the store after reset
			always_ff @(posedge clk)
			begin
				if (!nrst)
					mask[gi] <= MASK_RESET;
				else if (state == S_LOAD)
					mask[gi] <= store_rd[gi*8 +: 8];
				else if (wr_mask)
					mask[gi] <= bin[7:0];
			end

			// opto check and stored setting
			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					chan_ctrl[gi].opto_enable <= 1'b0;
					chan_ctrl[gi].setting <= SETTING_RESET;
				end
				else
				begin
					if (opto_set && sel)
						chan_ctrl[gi].opto_enable <= m_opto_on;
					if (value_setting_command_ok && sel)
						chan_ctrl[gi].setting <= op_bcd;
				end
			end

			assign ev_summary[gi] = |(esr[gi] & mask[gi]);
		end
	endgenerate

	// reply shifter, first character on top
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rbuf <= 56'h00000000000000;
			rlen <= 3'h0;
		end
		else if (reply_go)
		begin
			rbuf <= reply_sel;
			rlen <= len_sel;
		end
		else if ((state == S_REPLY) && tx_ready)
		begin
			rbuf <= {rbuf[47:0], 8'h00};
			rlen <= rlen - 3'h1;
		end
	end

	assign tx_data = rbuf[55:48];

	// nonvolatile masks
	mask_store u_store
	(
		.clk(clk),
		.npor(npor),
		.wr_en(save_go),
		.wr_data({mask[1], mask[0]}),
		.rd_data(store_rd)
	);
endmodule // remote_command_status_parser

`default_nettype wire

// ### remote_cmd_properties.sv
// Purpose: port checker for the remote command parser
// Assumes: one clock, nrst synchronous and active low
// Notes:   bound to the parser below the module
`default_nettype none
module remote_cmd_checker
(
	input wire logic clk, // clock
	input wire logic nrst, // reset
	input wire logic rx_ready, // byte taken
	input wire logic tx_valid, // reply offered
	input wire logic [7:0] tx_data, // reply byte
	input wire logic tx_ready, // reply taken
	input wire logic [1:0] inst_phase, // kind
	input wire remote_cmd_pkg::chan_ctrl_t [1:0] chan_ctrl, // controls
	input wire logic active_chan, // channel
	input wire logic value_mode, // mode
	input wire logic move_strobe, // move
	input wire logic [1:0] chan_reset, // reset pulse
	input wire logic [1:0] ev_summary // pending
);
	timeunit 1ns;
	timeprecision 1ns;
	import remote_cmd_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// reply handshake steps
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	sequence s_last;
		tx_valid && tx_ready && tx_data == ASC_LF;
	endsequence
	property p_reply_hold;
		s_stall |=> tx_valid && $stable(tx_data);
	endproperty
	a_reply_hold: assert property (p_reply_hold) else $error("reply byte lost");
	property p_reply_end;
		s_last |=> !tx_valid && rx_ready;
	endproperty
	a_reply_end: assert property (p_reply_end) else $error("reply end wrong");
	property p_no_rx;
		tx_valid |-> !rx_ready;
	endproperty
	a_no_rx: assert property (p_no_rx) else $error("input open in reply");
	// value set and opto results
	property p_move;
		move_strobe |-> value_mode && chan_reset == 2'h0 ##1 !move_strobe;
	endproperty
	a_move: assert property (p_move) else $error("move pulse wrong");
	property p_chan_reset;
		chan_reset != 2'h0 |-> chan_reset == (active_chan ? 2'h2 : 2'h1) ##1 chan_reset == 2'h0;
	endproperty
	a_chan_reset: assert property (p_chan_reset) else $error("reset pulse wrong");
	property p_mode;
		value_mode |=> value_mode;
	endproperty
	a_mode: assert property (p_mode) else $error("value mode lost");
	property p_setting;
		$changed(chan_ctrl[0].setting) |-> !active_chan
			&& chan_ctrl[0].setting <= (inst_phase[0] ? MAX_PHASE_BCD : MAX_ATTEN_BCD);
	endproperty
	a_setting: assert property (p_setting) else $error("setting wrong");
	property p_opto;
		$changed(chan_ctrl[0].opto_enable) |-> !active_chan && !$past(rx_ready);
	endproperty
	a_opto: assert property (p_opto) else $error("opto on idle channel");
	// enabled events stay until a read
	property p_sticky;
		ev_summary[0] && rx_ready |=> ev_summary[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("event lost");
endmodule // remote_cmd_checker
bind remote_command_status_parser remote_cmd_checker u_chk (.clk(clk), .nrst(nrst),
	.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.inst_phase(inst_phase), .chan_ctrl(chan_ctrl), .active_chan(active_chan),
	.value_mode(value_mode), .move_strobe(move_strobe), .chan_reset(chan_reset),
	.ev_summary(ev_summary));
`default_nettype wire

// ### host_link.sv
// Purpose: host side of the command link
// Assumes: bench fills txq and reads rxq; slow adds stalls
// Notes:   idle data line toggles every cycle, starting from the inverse of the last byte
`default_nettype none
module host_link
(
	input wire logic clk, // clock
	input wire logic rx_ready, // device takes byte
	output logic rx_valid, // byte offered
	output logic [7:0] rx_data, // byte
	input wire logic tx_valid, // reply offered
	input wire logic [7:0] tx_data, // reply byte
	output logic tx_ready // reply taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic slow = 1'b0;
	logic [1:0] cyc = 2'h0;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// bytes held until taken, whole commands with terminator
	always @(posedge clk)
	begin
		cyc <= cyc + 2'h1;
		tx_ready <= !(slow && cyc[1]);
		if (tx_valid && tx_ready)
			rxq.push_back(tx_data);
		if (!rx_valid || rx_ready)
		begin
			if (txq.size() > 0 && !(slow && cyc[0]))
			begin
				rx_valid <= 1'b1;
				rx_data <= txq.pop_front();
			end
			else
			begin
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
			end
		end
	end
endmodule // host_link
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench for the remote command parser
// Assumes: host_link model on the byte link
// Notes:   random case, values and events from a fixed seed
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import remote_cmd_pkg::*;
	logic clk, nrst, npor, rx_valid, rx_ready, tx_valid, tx_ready, active_chan;
	logic value_mode, move_strobe;
	logic [7:0] rx_data, tx_data, m, want;
	logic [1:0] inst_phase, chan_reset, ev_summary;
	chan_event_t [1:0] chan_ev;
	chan_ctrl_t [1:0] chan_ctrl;
	int n_errors = 0;
	int n_compared = 0;
	int seed = 32'h34b0;
	int cycles = 0;
	int n;
	int n_moves = 0;
	logic [1:0] seen_reset = 2'b00;
	// device and host
	remote_command_status_parser u_dut (.clk(clk), .nrst(nrst), .npor(npor),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .chan_ev(chan_ev), .inst_phase(inst_phase),
		.chan_ctrl(chan_ctrl), .active_chan(active_chan), .value_mode(value_mode),
		.move_strobe(move_strobe), .chan_reset(chan_reset), .ev_summary(ev_summary));
	host_link u_host (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	// clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			$display("Error at %0t: cycles 0x%0h limit 0x%0h", $time, cycles, 20000);
			tally_and_finish();
		end
	end
	// count move strobes and collect channel reset pulses
	always @(posedge clk)
	begin
		if (move_strobe === 1'b1)
			n_moves <= n_moves + 1;
		if (nrst)
			seen_reset <= seen_reset | chan_reset;
	end
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("Error at %0t: got 0x%h want 0x%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic chk_reply(input string exp);
		logic [63:0] got, w;
		got = '0;
		w = '0;
		foreach (exp[i]) w = {w[55:0], exp[i]};
		while (u_host.rxq.size() > 0) got = {got[55:0], u_host.rxq.pop_front()};
		n_compared++;
		if (got !== w)
		begin
			$display("Error at %0t: got 0x%h want 0x%h", $time, got, w);
			n_errors++;
		end
	endtask
	// expected reply texts
	function automatic string dec3(input int v);
		return $sformatf("%03d\n", v);
	endfunction
	function automatic logic [19:0] to_bcd(input int v);
		return {4'(v / 10000), 4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction
	function automatic string bcd_txt(input logic [19:0] s);
		return $sformatf("%h.%h\n", s[19:8], s[7:0]);
	endfunction
	task automatic push(input logic [63:0] w, input string s);
		logic [7:0] c;
		for (int i = 7; i >= 0; i--)
		begin
			c = w[i*8 +: 8];
			if (c != 8'h00)
				u_host.txq.push_back(($random(seed) & 1) ? c | CASE_GAP : c);
		end
		foreach (s[i]) u_host.txq.push_back(s[i]);
	endtask
	task automatic cmd(input logic [63:0] w, input string s);
		int k;
		push(w, s);
		k = 0;
		while ((u_host.txq.size() > 0 || rx_valid || rx_ready !== 1'b1) && k < 500)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	task automatic pulse(input int ch, input int b);
		@(posedge clk);
		chan_ev[ch] <= {b < 5 ? 3'(b + 1) : 3'h0, b == 5};
		@(posedge clk);
		chan_ev[ch] <= '0;
		#1;
	endtask
	task automatic do_reset(input logic por);
		@(posedge clk);
		nrst <= 1'b0;
		npor <= !por;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		npor <= 1'b1;
	endtask
	// main sequence
	initial
	begin
		nrst = 1'b0;
		npor = 1'b0;
		chan_ev = '0;
		inst_phase = 2'b10;
		do_reset(1'b1);
		for (int t = 0; t < 6; t++)
		begin
			want = 8'h00;
			for (int b = 0; b < 6; b++)
				if (($random(seed) & 1) || t >= 4)
				begin
					pulse(t % 2, b);
					want[b] = 1'b1;
				end
			cmd(t % 2 ? WORD_B_STATUS : WORD_A_STATUS, "?;");
			chk_reply(dec3(want));
			cmd(t % 2 ? WORD_B_STATUS : WORD_A_STATUS, "?;");
			chk_reply(dec3(0));
		end
		$display("events test done");
		u_host.slow = 1'b1;
		m = 8'($random(seed)) | 8'h20;
		cmd(WORD_A_ENABLE, $sformatf(" %0d;", m));
		cmd(WORD_B_ENABLE, "255;");
		cmd(WORD_A_ENABLE, "256;");
		cmd(WORD_A_ENABLE, "?;");
		chk_reply(dec3(m));
		pulse(0, 5);
		chk_val(20'(ev_summary), 20'h00001);
		cmd(WORD_SAVE_MASKS, ";");
		cmd(WORD_A_ENABLE, "0;");
		do_reset(1'b0);
		cmd(WORD_A_ENABLE, "?;");
		chk_reply(dec3(m));
		cmd(WORD_B_ENABLE, "?;");
		chk_reply(dec3(255));
		$display("mask test done");
		u_host.slow = 1'b0;
		cmd(WORD_SEL_FIRST, ";");
		cmd(WORD_OPTO_ON, ";");
		cmd(WORD_OPTO, "?;");
		chk_reply("1\n");
		cmd(WORD_SEL_SECOND, ";");
		chk_val(20'(active_chan), 20'h00001);
		cmd(WORD_OPTO, " ON;");
		cmd(WORD_OPTO, "?;");
		chk_reply("0\n");
		chk_val(20'({chan_ctrl[0].opto_enable, chan_ctrl[1].opto_enable}), 20'h00002);
		cmd(WORD_SEL_FIRST, ";");
		cmd(WORD_OPTO_OFF, ";");
		chk_val(20'(chan_ctrl[0].opto_enable), 20'h00000);
		$display("opto test done");
		chk_val(20'(value_mode), 20'h00000);
		push(WORD_SEL_SECOND, ";");
		cmd(WORD_VALUE_SET, "999.8\n");
		chk_val(chan_ctrl[1].setting, 20'h99980);
		cmd(WORD_VALUE_SET, "1000;");
		chk_val(chan_ctrl[1].setting, 20'h99980);
		cmd(WORD_B_STATUS, "?;");
		chk_reply(dec3(64));
		push(WORD_SEL_FIRST, ";");
		for (int t = 0; t < 4; t++)
		begin
			n = t == 0 ? 9999 : {$random(seed)} % 10000;
			cmd(WORD_VALUE_SET, $sformatf("%s%0d.%02d;", t[0] ? " " : "", n / 100, n % 100));
			chk_val(chan_ctrl[0].setting, to_bcd(n));
			cmd(WORD_VALUE_SET, "?;");
			chk_reply(bcd_txt(to_bcd(n)));
		end
		chk_val(20'(value_mode), 20'h00001);
		chk_val(20'(n_moves), 20'h00005);
		cmd(WORD_VALUE_SET, "100;");
		chk_val(chan_ctrl[0].setting, to_bcd(n));
		cmd(WORD_A_STATUS, "?;");
		chk_reply(dec3(64));
		chk_val(20'(seen_reset), 20'h00003);
		do_reset(1'b1);
		cmd(WORD_A_ENABLE, "?;");
		chk_reply(dec3(0));
		$display("value test done");
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
